/* design/otg_irq_cfg.svh */
`ifndef OTG_IRQ_CFG_SVH
`define OTG_IRQ_CFG_SVH
`define LATCH_SET_ADDR 8'h0A
`define LATCH_CLR_ADDR 8'h0B
`define FALL_SET_ADDR 8'h0C
`define FALL_CLR_ADDR 8'h0D
`define RISE_SET_ADDR 8'h0E
`define RISE_CLR_ADDR 8'h0F
`define REG_RESET 8'h00
`define FALL_WRITABLE 8'hBF
`define FALL_RSVD_BIT 6
`endif

/* design/otg_irq_pkg.sv */
package otg_irq_pkg;
  typedef logic [7:0] byte_t;
endpackage

/* design/otg_status_irq_latch.sv */
`timescale 1ns/1ns
`include "otg_irq_cfg.svh"
module otg_status_irq_latch
  import otg_irq_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  // register port from the serial slave
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // status signals, bit 7 carkit down to bit 0 vbus valid
  input wire logic [WIDTH-1:0] status_in,
  // status levels after synchronising
  output logic [WIDTH-1:0] status_level,
  // interrupt pin
  output logic irq_n
);

  logic [WIDTH-1:0] sync1_reg;
  logic [WIDTH-1:0] sync2_reg;
  logic [WIDTH-1:0] prev_reg;
  byte_t latch_reg;
  byte_t latch_next;
  byte_t fall_reg;
  byte_t fall_next;
  byte_t rise_reg;
  byte_t rise_next;
  logic [WIDTH-1:0] rise_edge;
  logic [WIDTH-1:0] fall_edge;
  logic [WIDTH-1:0] edge_set;

  // address decode
  wire wr_lset = reg_wr && reg_addr == `LATCH_SET_ADDR;
  wire wr_lclr = reg_wr && reg_addr == `LATCH_CLR_ADDR;
  wire wr_fset = reg_wr && reg_addr == `FALL_SET_ADDR;
  wire wr_fclr = reg_wr && reg_addr == `FALL_CLR_ADDR;
  wire wr_rset = reg_wr && reg_addr == `RISE_SET_ADDR;
  wire wr_rclr = reg_wr && reg_addr == `RISE_CLR_ADDR;

  // per bit edge detection on the synchronised level
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_edge
      assign rise_edge[gi] = sync2_reg[gi] && !prev_reg[gi];
      assign fall_edge[gi] = !sync2_reg[gi] && prev_reg[gi];
      assign edge_set[gi] = (rise_edge[gi] && rise_reg[gi]) || (fall_edge[gi] && fall_reg[gi]);
    end
  endgenerate

  // next values: clear first, then sets, so an edge wins over a clear
  assign latch_next = ((latch_reg & ~(wr_lclr ? reg_wdata : `REG_RESET))
                      | (wr_lset ? reg_wdata : `REG_RESET)) | edge_set;
  assign fall_next = ((fall_reg & ~(wr_fclr ? reg_wdata : `REG_RESET))
                     | (wr_fset ? reg_wdata : `REG_RESET)) & `FALL_WRITABLE;
  assign rise_next = (rise_reg & ~(wr_rclr ? reg_wdata : `REG_RESET))
                     | (wr_rset ? reg_wdata : `REG_RESET);

  // read mux: either address of a pair returns the contents
  assign reg_hit = (reg_addr == `LATCH_SET_ADDR) || (reg_addr == `LATCH_CLR_ADDR)
                   || (reg_addr == `FALL_SET_ADDR) || (reg_addr == `FALL_CLR_ADDR)
                   || (reg_addr == `RISE_SET_ADDR) || (reg_addr == `RISE_CLR_ADDR);
  assign reg_rdata = (wr_lset || wr_lclr || reg_addr == `LATCH_SET_ADDR || reg_addr == `LATCH_CLR_ADDR)
                     ? latch_reg
                     : (reg_addr == `FALL_SET_ADDR || reg_addr == `FALL_CLR_ADDR) ? fall_reg
                     : (reg_addr == `RISE_SET_ADDR || reg_addr == `RISE_CLR_ADDR) ? rise_reg
                     : `REG_RESET;
  assign status_level = prev_reg;

  // two flops against metastability, then the history flop that edges are judged against
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else if (clk_en) begin
      sync1_reg <= status_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // enable registers; fall bit 6 is masked in fall_next, so no write can set it
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fall_reg <= `REG_RESET;
      rise_reg <= `REG_RESET;
    end else if (clk_en) begin
      fall_reg <= fall_next;
      rise_reg <= rise_next;
    end
  end

  // latch and pin; the pin is fed from latch_next so both move on the same edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      latch_reg <= `REG_RESET;
      irq_n <= 1'b1;
    end else if (clk_en) begin
      latch_reg <= latch_next;
      irq_n <= ~|latch_next;
    end
  end

  // pin follows the latch in the same cycle
  property p_irq_tracks;
    @(posedge clk_sys) disable iff (!arst_n) irq_n == ~|latch_reg;
  endproperty
  a_irq_tracks: assert property (p_irq_tracks) else $error("irq pin disagrees with latch");

  // a set bit keeps the pin low until a clear write comes
  property p_irq_hold;
    @(posedge clk_sys) disable iff (!arst_n) (!irq_n && !(clk_en && wr_lclr)) |=> !irq_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq released without a clear");

  // every enabled rising edge lands in its own latch bit
  property p_rise_sets;
    @(posedge clk_sys) disable iff (!arst_n)
      (clk_en && |(rise_edge & rise_reg))
      |=> ((latch_reg & $past(rise_edge & rise_reg)) == $past(rise_edge & rise_reg));
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("enabled rise did not set latch");

  // every enabled falling edge lands in its own latch bit
  property p_fall_sets;
    @(posedge clk_sys) disable iff (!arst_n)
      (clk_en && |(fall_edge & fall_reg))
      |=> ((latch_reg & $past(fall_edge & fall_reg)) == $past(fall_edge & fall_reg));
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("enabled fall did not set latch");

  // ones written at the set address force latch bits
  property p_wset;
    @(posedge clk_sys) disable iff (!arst_n)
      (clk_en && wr_lset) |=> ((latch_reg & $past(reg_wdata)) == $past(reg_wdata));
  endproperty
  a_wset: assert property (p_wset) else $error("set write did not set latch");

  // ones written at the clear address clear latch bits, unless an edge sets them again
  property p_wclr;
    @(posedge clk_sys) disable iff (!arst_n)
      (clk_en && wr_lclr) |=> ((latch_reg & $past(reg_wdata) & ~$past(edge_set)) == `REG_RESET);
  endproperty
  a_wclr: assert property (p_wclr) else $error("clear write did not clear latch");

  // the disconnect event has no falling enable
  property p_fall_rsvd;
    @(posedge clk_sys) disable iff (!arst_n) !fall_reg[`FALL_RSVD_BIT];
  endproperty
  a_fall_rsvd: assert property (p_fall_rsvd) else $error("reserved fall enable bit set");

  // ones written at the rise set address enable those bits
  property p_rise_wr;
    @(posedge clk_sys) disable iff (!arst_n)
      (clk_en && wr_rset) |=> ((rise_reg & $past(reg_wdata)) == $past(reg_wdata));
  endproperty
  a_rise_wr: assert property (p_rise_wr) else $error("rise enable set failed");

  // the level output lags the pins by three enabled edges; four in a row are asked here, one more than the path needs
  property p_sync;
    @(posedge clk_sys) disable iff (!arst_n) clk_en [*4] |-> status_level == $past(status_in, 3);
  endproperty
  a_sync: assert property (p_sync) else $error("status level lag wrong");

  // an edge that meets a clear in the same cycle still leaves its bit set
  property p_edge_wins;
    @(posedge clk_sys) disable iff (!arst_n)
      (clk_en && |edge_set) |=> ((latch_reg & $past(edge_set)) == $past(edge_set));
  endproperty
  a_edge_wins: assert property (p_edge_wins) else $error("edge lost against a clear");

  // a low enable freezes every flop, the pin and the level output included
  property p_freeze;
    @(posedge clk_sys) disable iff (!arst_n)
      !clk_en |=> ($stable(latch_reg) && $stable(fall_reg) && $stable(rise_reg) && $stable(irq_n)
                  && $stable(status_level));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable was low");

  // ones written at the fall set address enable every bit but the reserved one
  property p_fall_wr;
    @(posedge clk_sys) disable iff (!arst_n)
      (clk_en && wr_fset)
      |=> ((fall_reg & $past(reg_wdata) & `FALL_WRITABLE) == ($past(reg_wdata) & `FALL_WRITABLE));
  endproperty
  a_fall_wr: assert property (p_fall_wr) else $error("fall enable set failed");

  // ones written at the fall clear address disable those bits
  property p_fall_clr;
    @(posedge clk_sys) disable iff (!arst_n)
      (clk_en && wr_fclr) |=> ((fall_reg & $past(reg_wdata)) == `REG_RESET);
  endproperty
  a_fall_clr: assert property (p_fall_clr) else $error("fall enable clear failed");

  // ones written at the rise clear address disable those bits
  property p_rise_clr;
    @(posedge clk_sys) disable iff (!arst_n)
      (clk_en && wr_rclr) |=> ((rise_reg & $past(reg_wdata)) == `REG_RESET);
  endproperty
  a_rise_clr: assert property (p_rise_clr) else $error("rise enable clear failed");

  // without a set write, a latch bit only comes up through an enabled edge
  property p_no_spurious;
    @(posedge clk_sys) disable iff (!arst_n)
      (clk_en && !wr_lset) |=> ((latch_reg & ~$past(latch_reg) & ~$past(edge_set)) == `REG_RESET);
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("latch bit set without a cause");

  // the pin goes high only with an empty latch
  property p_irq_release;
    @(posedge clk_sys) disable iff (!arst_n) $rose(irq_n) |-> (latch_reg == `REG_RESET);
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("irq released with latch bits set");

  // both latch addresses read back the latch
  property p_rd_latch;
    @(posedge clk_sys) disable iff (!arst_n)
      (reg_addr == `LATCH_SET_ADDR || reg_addr == `LATCH_CLR_ADDR) |-> (reg_rdata == latch_reg);
  endproperty
  a_rd_latch: assert property (p_rd_latch) else $error("latch read back wrong");

  // both fall enable addresses read back the fall enables
  property p_rd_fall;
    @(posedge clk_sys) disable iff (!arst_n)
      (reg_addr == `FALL_SET_ADDR || reg_addr == `FALL_CLR_ADDR) |-> (reg_rdata == fall_reg);
  endproperty
  a_rd_fall: assert property (p_rd_fall) else $error("fall enable read back wrong");

  // both rise enable addresses read back the rise enables
  property p_rd_rise;
    @(posedge clk_sys) disable iff (!arst_n)
      (reg_addr == `RISE_SET_ADDR || reg_addr == `RISE_CLR_ADDR) |-> (reg_rdata == rise_reg);
  endproperty
  a_rd_rise: assert property (p_rd_rise) else $error("rise enable read back wrong");

  // addresses outside the map give no hit and read as zero, so the slave can refuse them
  property p_unmapped;
    @(posedge clk_sys) disable iff (!arst_n)
      ((reg_addr < `LATCH_SET_ADDR) || (reg_addr > `RISE_CLR_ADDR)) |-> (!reg_hit && reg_rdata == `REG_RESET);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped address answered");

endmodule // otg_status_irq_latch

/* tb/status_src.sv */
`timescale 1ns/1ns
module status_src
  import otg_irq_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // level the detectors are asked to show
  input wire byte_t target,
  // detector outputs toward the block
  output byte_t status_in
);
  // detectors move only on a clock edge, so the block always sees a clean step
  always_ff @(posedge clk_sys) begin
    status_in <= target;
  end
endmodule // status_src

/* tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import otg_irq_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic clk_en = 1'b1;
  byte_t reg_addr = 8'h00;
  byte_t reg_wdata = 8'h00;
  byte_t target = 8'h00;
  wire byte_t reg_rdata;
  wire byte_t status_in;
  wire byte_t status_level;
  wire logic reg_hit;
  wire logic irq_n;
  int n_fail = 0;
  int num_checks = 0;
  otg_status_irq_latch DUT (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .status_in(status_in), .status_level(status_level), .irq_n(irq_n));
  status_src u_src (.clk_sys(clk_sys), .target(target), .status_in(status_in));
  // free running system clock
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input byte_t exp, input byte_t got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_bit(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask
  // the idle cycle after the strobe avoids two strobe assignments in one step
  task automatic wr(input byte_t a, input byte_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  // read data and hit are combinational, so they are looked at mid-cycle
  task automatic rdi(input byte_t a, input byte_t exp, input logic irq_exp);
    reg_addr <= a;
    @(negedge clk_sys);
    chk("reg_rdata", exp, reg_rdata);
    chk_bit("reg_hit", (a >= 8'h0A && a <= 8'h0F), reg_hit);
    chk_bit("irq_n", irq_exp, irq_n);
    @(posedge clk_sys);
  endtask
  // move the detectors, then give the synchroniser and latch time to settle
  task automatic settle(input byte_t t);
    target <= t;
    repeat (8) @(posedge clk_sys);
  endtask
  // levels come from flops, still looked at mid-cycle to stay clear of the edge
  task automatic lvl(input byte_t exp);
    @(negedge clk_sys);
    chk("status_level", exp, status_level);
    @(posedge clk_sys);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    for (int a = 10; a < 17; a++) rdi(byte_t'(a), 8'h00, 1'b1);
    wr(8'h0C, 8'hFF);
    rdi(8'h0C, 8'hBF, 1'b1);
    wr(8'h0E, 8'hFF);
    wr(8'h0F, 8'hFE);
    rdi(8'h0F, 8'h01, 1'b1);
    wr(8'h0D, 8'h00);
    rdi(8'h0D, 8'hBF, 1'b1);
    settle(8'h03);
    rdi(8'h0A, 8'h01, 1'b0);
    lvl(8'h03);
    settle(8'h40);
    settle(8'h00);
    rdi(8'h0B, 8'h03, 1'b0);
    wr(8'h0A, 8'h80);
    rdi(8'h0A, 8'h83, 1'b0);
    wr(8'h0B, 8'h03);
    rdi(8'h0B, 8'h80, 1'b0);
    wr(8'h0B, 8'h80);
    rdi(8'h0A, 8'h00, 1'b1);
    // bit 0 is already set when its rising edge meets a clear of it: the edge keeps it
    wr(8'h0A, 8'h01);
    target <= 8'h01;
    repeat (3) @(posedge clk_sys);
    wr(8'h0B, 8'h01);
    rdi(8'h0A, 8'h01, 1'b0);
    wr(8'h0B, 8'h01);
    rdi(8'h0A, 8'h00, 1'b1);
    // a low enable holds off both a write and the falling edge of bit 0
    clk_en <= 1'b0;
    wr(8'h0A, 8'h04);
    settle(8'h00);
    rdi(8'h0A, 8'h00, 1'b1);
    lvl(8'h01);
    clk_en <= 1'b1;
    settle(8'h00);
    rdi(8'h0A, 8'h01, 1'b0);
    lvl(8'h00);
    // a second reset in mid-run brings every register back to zero
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    for (int a = 10; a < 16; a++) rdi(byte_t'(a), 8'h00, 1'b1);
    lvl(8'h00);
    end_of_test();
  end
  // the sequence needs about one hundred and twenty cycles; this cuts a hang short
  initial begin
    #20000;
    n_fail++;
    end_of_test();
  end
endmodule // testbench
